// File: chan_port_cfg.svh
`ifndef CHAN_PORT_CFG_SVH
`define CHAN_PORT_CFG_SVH

// bit-mode command values
`define BITMODE_RESET_VAL 8'h00
`define BITMODE_ASYNC_VAL 8'h01
`define BITMODE_SYNC_VAL 8'h04

// status byte field positions
`define STAT_RX_AVAIL_BIT 0
`define STAT_TX_SPACE_BIT 1
`define STAT_SUSPEND_BIT 2
`define STAT_CONFIG_BIT 3

// reset values
`define PIN_DIR_RESET 8'h00
`define PIN_OUT_RESET 8'hff

// timing
`define CLK_PERIOD_NS 40
`define RD_DATA_DELAY_MAX_NS 50
`define RD_DATA_DELAY_CYC ((`RD_DATA_DELAY_MAX_NS / `CLK_PERIOD_NS) < 1 ? 1 : \
	(`RD_DATA_DELAY_MAX_NS / `CLK_PERIOD_NS))

`endif

// File: chan_port_pkg.sv
package chan_port_pkg;

	// channel operating mode, one-hot
	typedef enum logic [2:0] {
		MODE_BASE = 3'b001,
		MODE_ASYNC_BB = 3'b010,
		MODE_SYNC_BB = 3'b100
	} mode_t;

	// synchronous bit-bang cycle, one-hot
	typedef enum logic [5:0] {
		SB_IDLE = 6'b000001,
		SB_SAMPLE = 6'b000010,
		SB_SEND = 6'b000100,
		SB_APPLY = 6'b001000,
		SB_SETUP = 6'b010000,
		SB_UPDATE = 6'b100000
	} sb_state_t;

	// control lines of the processor bus
	typedef struct packed {
		logic cs_n;
		logic port_addr_bit;
		logic rd_n;
		logic wr_n;
	} cpu_ctl_t;

	// bit-mode setup command
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] dir_mask;
	} mode_cmd_t;

	// status byte layout
	typedef struct packed {
		logic [3:0] undefined;
		logic configured;
		logic suspended;
		logic tx_space_avail;
		logic rx_data_avail;
	} port_status_t;

endpackage

// File: byte_buf2.sv
`timescale 1ns/1ns
module byte_buf2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_ff [2];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] cnt_ff;
	logic in_ready_ff;
	logic out_valid_ff;
	logic do_push;
	logic do_pop;
	logic [1:0] nxt_cnt;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("byte_buf2 needs WIDTH of at least 1");
		end
	endgenerate

	// handshakes and next fill level
	assign do_push = in_valid & in_ready_ff;
	assign do_pop = out_valid_ff & out_ready;
	assign nxt_cnt = cnt_ff + {1'b0, do_push} - {1'b0, do_pop};
	assign in_ready = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data = mem_ff[rd_ptr_ff];

	// flags are registered from the next count so both ports come from flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			cnt_ff <= 2'h0;
			in_ready_ff <= 1'b1;
			out_valid_ff <= 1'b0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff ^ do_push;
			rd_ptr_ff <= rd_ptr_ff ^ do_pop;
			cnt_ff <= nxt_cnt;
			in_ready_ff <= (nxt_cnt != 2'h2);
			out_valid_ff <= (nxt_cnt != 2'h0);
		end
	end

	// storage carries no reset; it is read while valid, and also by a processor data read when empty
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end
endmodule

// File: chan_port.sv
`timescale 1ns/1ns
`include "chan_port_cfg.svh"
module chan_port #(
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// configuration and link state
	input wire logic cpu_fifo_sel,
	input wire logic mode_cmd_valid,
	input wire chan_port_pkg::mode_cmd_t mode_cmd,
	input wire logic usb_suspended,
	input wire logic usb_configured,
	input wire logic baud_tick,
	// bytes from the host (usb receive fifo)
	input wire logic rx_valid,
	input wire logic [DATA_W-1:0] rx_data,
	output logic rx_ready,
	// bytes to the host (usb transmit fifo)
	output logic tx_valid,
	output logic [DATA_W-1:0] tx_data,
	input wire logic tx_ready,
	output logic send_now,
	// processor bus control
	input wire chan_port_pkg::cpu_ctl_t cpu_ctl,
	// parallel pins
	input wire logic [DATA_W-1:0] pad_in,
	output logic [DATA_W-1:0] pad_out,
	output logic [DATA_W-1:0] pad_oe,
	output logic pin_sample_strobe_n,
	output logic pin_update_strobe_n
);
	generate
		if (DATA_W != 8) begin : g_chk
			$error("chan_port status byte needs DATA_W of 8");
		end
		if (`RD_DATA_DELAY_CYC < 1) begin : g_chk_rd
			$error("read data delay must be at least one cycle");
		end
	endgenerate

	chan_port_pkg::mode_t mode_ff;
	chan_port_pkg::sb_state_t sb_ff;
	chan_port_pkg::sb_state_t nxt_sb;
	chan_port_pkg::port_status_t status;
	logic [DATA_W-1:0] dir_ff;
	logic [DATA_W-1:0] pad_out_ff;
	logic [DATA_W-1:0] pad_oe_ff;
	logic [DATA_W-1:0] byte_ff;
	logic [DATA_W-1:0] tx_data_ff;
	logic tx_valid_ff;
	logic send_now_ff;
	logic sample_n_ff;
	logic update_n_ff;
	logic pend_ff;
	logic ab_applied_ff;
	logic rd_prev_ff;
	logic wr_prev_ff;
	logic cpu_rd_drive_ff;

	// receive buffer signals
	logic buf_valid;
	logic [DATA_W-1:0] buf_data;
	logic buf_pop;

	// decode
	logic cpu_active;
	logic cpu_sel;
	logic rd_fall;
	logic rd_rise;
	logic wr_rise;
	logic cpu_rd_data;
	logic cpu_rd_stat;
	logic cpu_wr_data;
	logic cpu_wr_flush;
	logic cpu_drive;
	logic tx_room;
	logic tx_take;
	logic ab_pop;
	logic ab_apply;
	logic ab_sample;
	logic sb_start;
	logic sb_push;
	logic [DATA_W-1:0] cpu_rd_byte;

	// host bytes pass a two-entry buffer so a stalled consumer drops nothing
	byte_buf2 #(
		.WIDTH(DATA_W)
	) u_rx_buf (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(rx_valid),
		.in_data(rx_data),
		.in_ready(rx_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(buf_pop)
	);

	// processor bus decode; strobes are sampled, edges found against the last cycle
	assign cpu_active = cpu_fifo_sel & (mode_ff == chan_port_pkg::MODE_BASE);
	assign cpu_sel = cpu_active & ~cpu_ctl.cs_n;
	assign rd_fall = rd_prev_ff & ~cpu_ctl.rd_n;
	assign rd_rise = ~rd_prev_ff & cpu_ctl.rd_n;
	assign wr_rise = ~wr_prev_ff & cpu_ctl.wr_n;
	assign cpu_rd_data = cpu_sel & rd_fall & ~cpu_ctl.port_addr_bit;
	assign cpu_rd_stat = cpu_sel & rd_fall & cpu_ctl.port_addr_bit;
	assign cpu_wr_data = cpu_sel & wr_rise & ~cpu_ctl.port_addr_bit;
	assign cpu_wr_flush = cpu_sel & wr_rise & cpu_ctl.port_addr_bit;
	// the bus lets go on the edge that sees rd_n rise, so it never fights the next writer
	assign cpu_drive = (cpu_rd_drive_ff & ~rd_rise & cpu_active) | cpu_rd_data | cpu_rd_stat;

	// status byte; upper nibble reads as zero
	assign status.undefined = 4'h0;
	assign status.configured = usb_configured;
	assign status.suspended = usb_suspended;
	assign status.tx_space_avail = tx_room;
	assign status.rx_data_avail = buf_valid;
	assign cpu_rd_byte = cpu_rd_stat ? status : buf_data;

	// transmit slot: a new byte is taken only when the slot is free
	assign tx_room = ~tx_valid_ff;
	assign tx_take = tx_valid_ff & tx_ready;

	// async bit-bang: latch a byte, show it on the next baud tick
	assign ab_pop = (mode_ff == chan_port_pkg::MODE_ASYNC_BB) & buf_valid & ~pend_ff;
	assign ab_apply = (mode_ff == chan_port_pkg::MODE_ASYNC_BB) & pend_ff & baud_tick;
	assign ab_sample = (mode_ff == chan_port_pkg::MODE_ASYNC_BB) & baud_tick & tx_room;

	// sync bit-bang starts only with a host byte and room for its sample
	assign sb_start = (mode_ff == chan_port_pkg::MODE_SYNC_BB) & (sb_ff == chan_port_pkg::SB_IDLE)
		& buf_valid & tx_room;
	assign sb_push = (sb_ff == chan_port_pkg::SB_SEND);

	assign buf_pop = (cpu_rd_data & buf_valid) | ab_pop | sb_start;

	// sync bit-bang sequence
	always_comb begin
		nxt_sb = sb_ff;
		unique case (sb_ff)
			chan_port_pkg::SB_IDLE: begin
				if (sb_start) begin
					nxt_sb = chan_port_pkg::SB_SAMPLE;
				end
			end
			chan_port_pkg::SB_SAMPLE: nxt_sb = chan_port_pkg::SB_SEND;
			chan_port_pkg::SB_SEND: nxt_sb = chan_port_pkg::SB_APPLY;
			chan_port_pkg::SB_APPLY: nxt_sb = chan_port_pkg::SB_SETUP;
			chan_port_pkg::SB_SETUP: nxt_sb = chan_port_pkg::SB_UPDATE;
			chan_port_pkg::SB_UPDATE: nxt_sb = chan_port_pkg::SB_IDLE;
			default: nxt_sb = chan_port_pkg::SB_IDLE;
		endcase
		if (mode_ff != chan_port_pkg::MODE_SYNC_BB) begin
			nxt_sb = chan_port_pkg::SB_IDLE;
		end
	end

	// mode and pin direction from the setup command
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= chan_port_pkg::MODE_BASE;
			dir_ff <= `PIN_DIR_RESET;
		end else if (mode_cmd_valid) begin
			dir_ff <= mode_cmd.dir_mask;
			if (mode_cmd.mode == `BITMODE_ASYNC_VAL) begin
				mode_ff <= chan_port_pkg::MODE_ASYNC_BB;
			end else if (mode_cmd.mode == `BITMODE_SYNC_VAL) begin
				mode_ff <= chan_port_pkg::MODE_SYNC_BB;
			end else begin
				mode_ff <= chan_port_pkg::MODE_BASE;
			end
		end
	end

	// strobe history and sync state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_prev_ff <= 1'b1;
			wr_prev_ff <= 1'b1;
			sb_ff <= chan_port_pkg::SB_IDLE;
			ab_applied_ff <= 1'b0;
		end else begin
			rd_prev_ff <= cpu_ctl.rd_n;
			wr_prev_ff <= cpu_ctl.wr_n;
			sb_ff <= nxt_sb;
			ab_applied_ff <= ab_apply; // pins moved last edge, strobe follows once settled
		end
	end

	// transmit slot toward the host; a push only ever lands in a free slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_ff <= 1'b0;
			tx_data_ff <= '0;
		end else if (tx_room & cpu_wr_data) begin
			tx_valid_ff <= 1'b1;
			tx_data_ff <= pad_in;
		end else if (sb_push) begin
			tx_valid_ff <= 1'b1;
			tx_data_ff <= byte_ff;
		end else if (ab_sample) begin
			tx_valid_ff <= 1'b1;
			tx_data_ff <= pad_in;
		end else if (tx_take) begin
			tx_valid_ff <= 1'b0;
		end
	end

	// flush request, one cycle per write at address 1
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			send_now_ff <= 1'b0;
		end else begin
			send_now_ff <= cpu_wr_flush;
		end
	end

	// held byte: async pending byte, or the sync host byte and then its sample
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_ff <= 1'b0;
			byte_ff <= '0;
		end else if (ab_pop) begin
			pend_ff <= 1'b1;
			byte_ff <= buf_data;
		end else if (ab_apply) begin
			pend_ff <= 1'b0;
		end else if (sb_start) begin
			byte_ff <= buf_data;
		end else if (sb_ff == chan_port_pkg::SB_SAMPLE) begin
			byte_ff <= pad_in;
		end else if (mode_ff != chan_port_pkg::MODE_ASYNC_BB) begin
			pend_ff <= 1'b0;
		end
	end

	// the host byte must survive the sample step, so keep a copy for the apply step
	logic [DATA_W-1:0] sb_out_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sb_out_ff <= `PIN_OUT_RESET;
		end else if (sb_start) begin
			sb_out_ff <= buf_data;
		end
	end

	// pin drive: processor read data or bit-bang output latch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out_ff <= `PIN_OUT_RESET;
			cpu_rd_drive_ff <= 1'b0;
		end else if (cpu_rd_data | cpu_rd_stat) begin
			pad_out_ff <= cpu_rd_byte;
			cpu_rd_drive_ff <= 1'b1;
		end else if (rd_rise | ~cpu_active) begin
			cpu_rd_drive_ff <= 1'b0;
			if (ab_apply) begin
				pad_out_ff <= byte_ff;
			end else if (sb_ff == chan_port_pkg::SB_APPLY) begin
				pad_out_ff <= sb_out_ff;
			end
		end
	end

	// output enables follow the direction mask only in bit-bang modes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_oe_ff <= '0;
		end else if (mode_ff != chan_port_pkg::MODE_BASE) begin
			pad_oe_ff <= dir_ff;
		end else begin
			pad_oe_ff <= {DATA_W{cpu_drive}};
		end
	end

	// strobes on pins; async mode mirrors the internal access pulses
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_n_ff <= 1'b1;
			update_n_ff <= 1'b1;
		end else if (mode_ff == chan_port_pkg::MODE_ASYNC_BB) begin
			sample_n_ff <= ~ab_sample;
			update_n_ff <= ~ab_applied_ff;
		end else if (mode_ff == chan_port_pkg::MODE_SYNC_BB) begin
			// rise with the sample push, fall with the new pin value
			if (sb_ff == chan_port_pkg::SB_SEND) begin
				sample_n_ff <= 1'b1;
			end else if (sb_ff == chan_port_pkg::SB_APPLY) begin
				sample_n_ff <= 1'b0;
			end
			update_n_ff <= ~(sb_ff == chan_port_pkg::SB_SETUP);
		end else begin
			sample_n_ff <= 1'b1;
			update_n_ff <= 1'b1;
		end
	end

	// outputs straight from flops
	assign tx_valid = tx_valid_ff;
	assign tx_data = tx_data_ff;
	assign send_now = send_now_ff;
	assign pad_out = pad_out_ff;
	assign pad_oe = pad_oe_ff;
	assign pin_sample_strobe_n = sample_n_ff;
	assign pin_update_strobe_n = update_n_ff;
endmodule

// File: chan_port_assertions.sv
`timescale 1ns/1ns
module chan_port_checker #(
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// stimulus side
	input wire logic cpu_fifo_sel,
	input wire logic mode_cmd_valid,
	input wire chan_port_pkg::cpu_ctl_t cpu_ctl,
	input wire logic usb_suspended,
	input wire logic usb_configured,
	input wire logic tx_ready,
	// design outputs
	input wire logic tx_valid,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic send_now,
	input wire logic [DATA_W-1:0] pad_out,
	input wire logic [DATA_W-1:0] pad_oe,
	input wire logic pin_sample_strobe_n,
	input wire logic pin_update_strobe_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// processor bus: select and strobe edges decide bus drive and flush
	a_read_drives: assert property (cpu_fifo_sel && !cpu_ctl.cs_n && $fell(cpu_ctl.rd_n) |=> pad_oe == 8'hff) else $error("no drive");
	a_read_release: assert property (cpu_fifo_sel && $rose(cpu_ctl.rd_n) |=> pad_oe == 8'h00) else $error("bus held");
	a_deselect_quiet: assert property (cpu_ctl.cs_n |=> !send_now) else $error("flush while deselected");
	a_flush_pulse: assert property (cpu_fifo_sel && !cpu_ctl.cs_n && cpu_ctl.port_addr_bit && $rose(cpu_ctl.wr_n) |=> send_now ##1 !send_now) else $error("flush pulse");
	a_flush_cause: assert property (send_now |-> $past(cpu_ctl.wr_n && cpu_ctl.port_addr_bit) && !$past(cpu_ctl.wr_n, 2)) else $error("flush cause");
	a_status_link: assert property (cpu_fifo_sel && !cpu_ctl.cs_n && cpu_ctl.port_addr_bit && $fell(cpu_ctl.rd_n) |=> pad_out[3:2] == $past({usb_configured, usb_suspended})) else $error("status");
	// pin strobes: update pulse is one cycle and pins are settled under it
	a_update_once: assert property ($fell(pin_update_strobe_n) |=> pin_update_strobe_n) else $error("update width");
	a_update_settled: assert property ($fell(pin_update_strobe_n) |-> $stable(pad_out)) else $error("pins moving");
	// leaving sync mode lifts the idle-low strobe; that edge carries no sample
	a_sample_to_tx: assert property ($rose(pin_sample_strobe_n) && !$past(mode_cmd_valid, 2)
		|-> tx_valid || $past(tx_valid)) else $error("sample not sent");
	// a stalled host must not lose or alter the pending sample
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx dropped");
	c_flush: cover property (send_now);
	c_update: cover property ($fell(pin_update_strobe_n));
	c_sample: cover property ($rose(pin_sample_strobe_n));
endmodule

bind chan_port chan_port_checker #(.DATA_W(DATA_W)) u_checker (.ref_clk, .rst_n, .cpu_fifo_sel, .mode_cmd_valid, .cpu_ctl,
	.usb_suspended, .usb_configured, .tx_ready, .tx_valid, .tx_data, .send_now, .pad_out, .pad_oe,
	.pin_sample_strobe_n, .pin_update_strobe_n);

// File: pin_logic_model.sv
`timescale 1ns/1ns
module pin_logic_model (
	// device pins
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic pin_update_strobe_n,
	output logic [7:0] pad_in,
	// outside driver
	input wire logic [7:0] ext_val,
	input wire logic ext_en,
	output logic [7:0] strobe_latch
);
	// each line follows its driver; a released line rises on its pull-up
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & (ext_en ? ext_val : 8'hff));
	// outside logic clocked by the update strobe, so it only sees settled pins
	always @(posedge pin_update_strobe_n) strobe_latch <= pad_in;
endmodule

// File: chan_port_bench.sv
`timescale 1ns/1ns
`include "chan_port_cfg.svh"
module chan_port_bench;
	logic ref_clk = 0, rst_n = 0, cpu_fifo_sel = 0, mode_cmd_valid = 0, usb_suspended = 0, usb_configured = 0;
	logic baud_tick = 0, rx_valid = 0, tx_ready = 0, ext_en = 0, stall_en = 0;
	logic rx_ready, tx_valid, send_now, pin_sample_strobe_n, pin_update_strobe_n;
	logic [7:0] rx_data = 0, ext_val = 0, tx_data, pad_in, pad_out, pad_oe, latch, prev, rd, oe, dir, b;
	logic [15:0] n;
	chan_port_pkg::mode_cmd_t mode_cmd = '0;
	chan_port_pkg::cpu_ctl_t cpu_ctl = 4'hf;
	logic [15:0] expq[$];
	int fails = 0, checks_done = 0, flushes = 0;
	always #20 ref_clk = ~ref_clk;
	chan_port u_dut (.ref_clk, .rst_n, .cpu_fifo_sel, .mode_cmd_valid, .mode_cmd, .usb_suspended, .usb_configured,
		.baud_tick, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .send_now, .cpu_ctl, .pad_in,
		.pad_out, .pad_oe, .pin_sample_strobe_n, .pin_update_strobe_n);
	pin_logic_model u_pins (.pad_out, .pad_oe, .pin_update_strobe_n, .pad_in, .ext_val, .ext_en, .strobe_latch(latch));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// every drive lands one step after the rising edge
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// valid stays up so bytes may go back to back; the caller drops it
	task automatic send_rx(input logic [7:0] v);
		rx_valid = 1;
		rx_data = v;
		@(negedge ref_clk);
		while (rx_ready !== 1'b1) @(negedge ref_clk);
		tick(1);
	endtask
	// strobes never overlap and the address only moves while both are idle
	task automatic cpu_op(input logic cs_n, input logic a, input logic is_rd);
		cpu_ctl.cs_n = cs_n;
		cpu_ctl.port_addr_bit = a;
		tick(1);
		if (is_rd) cpu_ctl.rd_n = 0;
		else cpu_ctl.wr_n = 0;
		tick(3);
		rd = pad_out;
		oe = pad_oe;
		cpu_ctl.rd_n = 1;
		cpu_ctl.wr_n = 1;
		tick(2);
		cpu_ctl.cs_n = 1;
		tick(1);
	endtask
	task automatic set_mode(input logic [7:0] m, input logic [7:0] d);
		mode_cmd = {m, d};
		mode_cmd_valid = 1;
		dir = d;
		tick(1);
		mode_cmd_valid = 0;
		tick(2);
	endtask
	task automatic baud_pulse();
		baud_tick = 1;
		tick(1);
		baud_tick = 0;
		tick(4);
	endtask
	// random host stalls while enabled
	always @(posedge ref_clk) tx_ready <= #1 stall_en ? (($urandom % 3) != 0) : 1'b1;
	// scoreboard: each byte to the host is matched with the oldest note
	always @(negedge ref_clk) begin
		if (send_now === 1'b1) flushes++;
		if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (expq.size() == 0) check(8'h01, 8'h00, "unexpected tx byte");
			else begin
				n = expq.pop_front();
				check(tx_data & n[15:8], n[7:0] & n[15:8], "tx byte");
			end
		end
	end
	initial begin
		#200000;
		fails++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h96fa9f9f));
		tick(4);
		rst_n = 1;
		check(pad_out, `PIN_OUT_RESET, "pad_out");
		check(pad_oe, `PIN_DIR_RESET, "pad_oe");
		check({4'h0, tx_valid, send_now, pin_sample_strobe_n, pin_update_strobe_n}, 8'h03, "flags");
		// processor mode: fill the receive buffer, then read, status and flush
		cpu_fifo_sel = 1;
		usb_configured = 1;
		usb_suspended = 1'($urandom);
		b = 8'($urandom);
		send_rx(b);
		send_rx(~b);
		rx_valid = 0;
		tick(2);
		check(8'(rx_ready), 8'h00, "full buffer");
		cpu_op(0, 0, 1);
		check(rd, b, "read data");
		cpu_op(0, 1, 1);
		check(rd & 8'h0f, {5'h01, usb_suspended, 2'b11}, "status");
		cpu_op(1, 0, 1);
		check(oe, 8'h00, "deselected read");
		cpu_op(0, 0, 1);
		check(rd, ~b, "second read");
		cpu_op(0, 1, 1);
		check(rd & 8'h0f, {5'h01, usb_suspended, 2'b10}, "drained status");
		ext_en = 1;
		ext_val = 8'($urandom);
		expq.push_back({8'hff, ext_val});
		cpu_op(0, 0, 0);
		cpu_op(1, 1, 0);
		cpu_op(0, 1, 0);
		check(8'(flushes), 8'h01, "flushes");
		// second reset in mid-run leaves pins at their reset level
		rst_n = 0;
		cpu_fifo_sel = 0;
		tick(2);
		rst_n = 1;
		check(pad_out, `PIN_OUT_RESET, "pad_out again");
		// synchronous bit-bang with the host stalling
		stall_en = 1;
		ext_val = 8'ha5;
		set_mode(`BITMODE_SYNC_VAL, 8'h0f);
		check(pad_oe, 8'h0f, "sync dir");
		prev = `PIN_OUT_RESET;
		for (int i = 0; i < 4; i++) begin
			b = (i == 3) ? prev : 8'($urandom);
			expq.push_back({8'hff, (prev & dir) | (ext_val & ~dir)});
			prev = b;
			send_rx(b);
		end
		rx_valid = 0;
		tick(30);
		check(pad_out & dir, prev & dir, "sync pins");
		check(latch & dir, prev & dir, "strobe latch");
		// asynchronous bit-bang: pins move only on a tick after new data
		stall_en = 0;
		set_mode(`BITMODE_ASYNC_VAL, 8'h0f);
		send_rx(8'h3c);
		rx_valid = 0;
		tick(5);
		check(pad_out & dir, prev & dir, "pins before tick");
		expq.push_back({8'hf0, ext_val});
		baud_pulse();
		check(pad_out & dir, 8'h3c & dir, "async pins");
		check(latch & dir, 8'h3c & dir, "async latch");
		expq.push_back({8'hff, (8'h3c & dir) | (ext_val & ~dir)});
		baud_pulse();
		check(pad_out & dir, 8'h3c & dir, "pins held");
		// all inputs: a write is still needed to get the pins read
		set_mode(`BITMODE_SYNC_VAL, 8'h00);
		expq.push_back({8'hff, ext_val});
		send_rx(8'h5a);
		rx_valid = 0;
		tick(30);
		check(pad_oe, 8'h00, "input only");
		check(8'(expq.size()), 8'h00, "missing tx");
		// any other mode value falls back to processor mode, which frees the pins
		set_mode(`BITMODE_RESET_VAL, 8'hff);
		check(pad_oe, 8'h00, "base mode oe");
		give_verdict();
	end
endmodule
